// ### test/csa_conv_model.sv
`timescale 1ns/100ps
// Converter model: fixed results per channel, calibration slot takes cal_sense
module csa_conv_model
  import csa_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic conv_active,
  input wire logic [2:0] conv_chan,
  input wire logic [16:0] cal_sense,
  output csa_sample_type sample
);
  // Slot was running last cycle
  logic hold_q;
  // Result for the channel in conversion
  csa_sample_type good;
  assign good = (conv_chan == CAL_CH) ? {cal_sense, 17'h00000} :
    {17'h00028 + 17'(conv_chan) * 17'h10, 17'h003E8 + 17'(conv_chan) * 17'h64};
  // Window covers slot plus calc cycle
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      hold_q <= 1'b0;
    else
      hold_q <= conv_active;
  // Inverse outside the window, never a stale value
  assign sample = (conv_active || hold_q) ? good : ~good;
endmodule : csa_conv_model

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import csa_pkg::*;
  localparam int PER = 200; // Shortened round-robin period
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  csa_bus_req_type bus_req = '0;
  logic [31:0] rdata, v;
  csa_sample_type sample;
  logic [16:0] cal_sense = 17'h00003; // Calibration result the model returns
  logic conv_active, sleep, alert_n, prev_act;
  logic [2:0] conv_chan;
  logic [2:0] chq[$]; // Channel of each slot start
  int tq[$]; // Cycle of each slot start
  int n_mismatch, tests_run, cyc, alo, acc_cc, t0, t1;
  logic [31:0] a0[3], c0[3];
  logic [2:0] ord[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [31:0] dacc[3] = '{32'h0000_1211, 32'h0000_0035, 32'h0000_04B0};

  always #5 mclk = ~mclk;

  csa_sequencer #(.SLOT_CYC(8), .PER0_CYC(PER), .PER1_CYC(PER), .PER2_CYC(PER), .PER3_CYC(PER)) dut (
    .mclk(mclk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .sample(sample),
    .conv_active(conv_active), .conv_chan(conv_chan), .sleep(sleep), .alert_n(alert_n));
  csa_conv_model conv (.mclk(mclk), .nrst(nrst), .conv_active(conv_active), .conv_chan(conv_chan),
    .cal_sense(cal_sense), .sample(sample));

  // Slot log, alert counters, timeout
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    prev_act <= conv_active;
    if (conv_active && !prev_act)
    begin
      chq.push_back(conv_chan);
      tq.push_back(cyc);
    end
    if (!alert_n)
      alo <= alo + 1;
    if (!alert_n && conv_active)
      acc_cc <= acc_cc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask : wr

  // Read strobe, data taken in the next cycle
  task automatic rv(input logic [7:0] a);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    #1 v = rdata;
  endtask : rv

  // Read and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rv(a);
    chk(v, e);
  endtask : rc

  // Snapshot, wait for sleep, then host spacing
  task automatic shot(input logic [31:0] code);
    int i;
    wr(ADDR_CMD, code);
    repeat (3) @(posedge mclk);
    for (i = 0; i < 3000 && sleep !== 1'b1; i++)
      @(posedge mclk);
    chk({31'h0, sleep}, 32'h1);
    repeat (200) @(posedge mclk);
  endtask : shot

  // Run a mode, check channel-0 period and calibration slot
  task automatic mode_run(input logic [31:0] ctrl, input int per, input logic cal);
    int i0;
    logic seen_cal;
    wr(ADDR_CTRL, ctrl);
    repeat (250) @(posedge mclk);
    chq.delete();
    tq.delete();
    repeat (500) @(posedge mclk);
    seen_cal = 1'b0;
    i0 = -1;
    foreach (chq[i])
    begin
      if (chq[i] == CAL_CH)
        seen_cal = 1'b1;
      if (chq[i] == 3'h0)
      begin
        if (i0 >= 0)
          chk(32'(tq[i] - tq[i0]), 32'(per));
        i0 = i;
      end
    end
    chk({31'h0, seen_cal}, {31'h0, cal});
  endtask : mode_run

  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rc(ADDR_CTRL, 32'h0000_0F30);
    rc(ADDR_ACCSRC, 32'h0);
    rc(ADDR_LIMIT, 32'h0000_7FFF);
    rc(8'h3C, 32'h0);
    mode_run(32'h0000_0F30, PER, 1'b1);
    rc(ADDR_OFFSET, 32'h3);
    mode_run(32'h0000_0130, PER, 1'b1);
    mode_run(32'h0000_0332, 27, 1'b1);
    mode_run(32'h0000_0331, 18, 1'b0);
    rc(ADDR_OFFSET, 32'h3);
    // New calibration result that burst must not pick up
    cal_sense <= 17'h00005;
    t0 = alo;
    mode_run(32'h0000_1131, 9, 1'b0);
    chk(32'(alo - t0), 32'h0);
    rc(ADDR_OFFSET, 32'h3);
    cal_sense <= 17'h00003;
    mode_run(32'h0000_0030, 0, 1'b0);
    chk(32'(chq.size()), 32'h0);
    // Single shot over three channels, three sources
    wr(ADDR_ACCSRC, 32'h24);
    wr(ADDR_CTRL, 32'h0000_0733);
    chq.delete();
    repeat (300) @(posedge mclk);
    chk(32'(chq.size()), 32'h0);
    for (int k = 1; k < 4; k++)
    begin
      for (int c = 0; c < 3; c++)
      begin
        rv(8'h40 + 8'(c * 16));
        a0[c] = v;
        rv(8'h48 + 8'(c * 16));
        c0[c] = v;
      end
      chq.delete();
      shot(32'(k));
      chk(32'(chq.size()), 32'h4);
      foreach (chq[i])
        chk({29'h0, chq[i]}, {29'h0, ord[i & 3]});
      for (int c = 0; c < 3; c++)
      begin
        rc(8'h40 + 8'(c * 16), a0[c] + dacc[c]);
        rc(8'h48 + 8'(c * 16), c0[c] + 32'h1);
        rc(8'h44 + 8'(c * 16), 32'h0);
      end
      rc(8'h4C, 32'h01F4_0009);
      rc(8'h80, 32'h01F4_0009);
    end
    // Eight-times single shot on channel 0
    wr(ADDR_ACCSRC, 32'h0);
    wr(ADDR_CTRL, 32'h0000_0134);
    rv(8'h40);
    a0[0] = v;
    rv(8'h48);
    c0[0] = v;
    shot(32'h1);
    rc(8'h40, a0[0] + 32'h0000_9088);
    rc(8'h44, 32'h0);
    rc(8'h48, c0[0] + 32'h8);
    rc(8'h80, 32'h01F4_0009);
    rc(8'h4C, 32'h01F4_0009);
    // Completion pulse width
    wr(ADDR_CTRL, 32'h0000_1133);
    t0 = alo;
    shot(32'h1);
    repeat (600) @(posedge mclk);
    chk(32'(alo - t0), 32'd500);
    // Latched limit alert, set only at cycle end
    wr(ADDR_LIMIT, 32'h0);
    wr(ADDR_CTRL, 32'h0000_2133);
    t1 = acc_cc;
    shot(32'h2);
    chk({31'h0, alert_n}, 32'h0);
    chk(32'(acc_cc - t1), 32'h0);
    rc(ADDR_STATUS, 32'h0000_0610);
    repeat (300) @(posedge mclk);
    chk({31'h0, alert_n}, 32'h0);
    wr(ADDR_STATUS, 32'h0000_00F0);
    repeat (3) @(posedge mclk);
    chk({31'h0, alert_n}, 32'h1);
    rc(ADDR_STATUS, 32'h0000_0200);
    close_out();
  end
endmodule : tb_top

// ### verilog/csa_pkg.sv
package csa_pkg;

  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  // Aggregate conversion slot rate, samples per second
  localparam int CONV_RATE_SPS = 5120;
  // Selectable round-robin rates, samples per second
  localparam int RATE0_SPS = 8;
  localparam int RATE1_SPS = 64;
  localparam int RATE2_SPS = 256;
  localparam int RATE3_SPS = 1024;
  // Conversion-complete pulse on the alert pin
  localparam int CC_PULSE_US = 5;
  localparam int CC_PULSE_CYC = CC_PULSE_US * 1000 / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACCSRC = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h14;
  // Per-channel block: addr[7:6], stride 0x10
  localparam logic [1:0] CHBLK_TAG = 2'h1;
  // Averaged results: addr[7:4], stride 0x04
  localparam logic [3:0] AVGBLK_TAG = 4'h8;

  // Control register fields and reset value
  localparam int CTRL_RATE_LSB = 4;
  localparam int CTRL_EN_LSB = 8;
  localparam int CTRL_CCEN_BIT = 12;
  localparam int CTRL_LIMEN_BIT = 13;
  localparam int CTRL_OVFEN_BIT = 14;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7F37;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0F30;
  localparam logic [7:0] ACCSRC_RESET = 8'h00;
  localparam logic [15:0] LIMIT_RESET = 16'h7FFF;

  // Accumulator source codes
  localparam logic [1:0] SRC_POWER = 2'h0;
  localparam logic [1:0] SRC_SENSE = 2'h1;
  localparam logic [1:0] SRC_BUS = 2'h2;

  // Channel indices
  localparam logic [2:0] CAL_CH = 3'h4;
  localparam logic [2:0] NO_CH = 3'h7;
  localparam logic [2:0] LAST_PASS = 3'h7;

  // Accumulator limits
  localparam logic [55:0] ACC_MAX = 56'h7F_FFFF_FFFF_FFFF;
  localparam logic [55:0] ACC_MIN = 56'h80_0000_0000_0000;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_CONT = 3'h0,
    MODE_BURST = 3'h1,
    MODE_FAST = 3'h2,
    MODE_SINGLE = 3'h3,
    MODE_SINGLE8 = 3'h4
  } csa_mode_type;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_CONV = 4'h2,
    ST_CALC = 4'h4,
    ST_GAP = 4'h8
  } csa_state_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } csa_bus_req_type;

  // Converter result pair
  typedef struct packed {
    logic [16:0] sense;
    logic [16:0] bus;
  } csa_sample_type;

endpackage : csa_pkg

// ### verilog/csa_sequencer.sv
`timescale 1ns/100ps
// Summary of operation
// [RQ1] Per-channel accumulator source: sense, bus, power
// [RQ2] Cycle done after all channels plus calibration
// [RQ3] After conversion: power, accumulate, update averages
// [RQ4] Channels converted one at a time, in order
// [RQ5] Continuous period: slots, calculation, then sleep; code waits out the period in ST_GAP with sleep low
// [RQ6] Disabled channels skipped, rate unchanged
// [RQ7] No channel enabled means sleep, no conversions
// [RQ8] Burst: back to back, no calibration slot
// [RQ9] Burst keeps last stored offset value
// [RQ10] Burst rate 5120 SPS over active channels
// [RQ11] Fast: back to back with calibration slot
// [RQ12] Fast rate 5120 over active plus one
// [RQ13] Single shot converts once, accumulates, counts
// [RQ14] Single shot starts only on snapshot command
// [RQ15] Single shot returns to sleep when done
// [RQ16] Host waits about 2 ms between snapshots
// [RQ17] Eight-times mode takes eight samples, averages
// [RQ18] Eight-times mode accumulates eight, count plus eight
// [RQ19] Averaged registers hold mean, raw holds eighth
// [RQ20] Alerts: cycle complete, overflow, limit exceeded
// [RQ21] Latched low alert; completion gives 5 us pulse
// [RQ22] Alerts registered at end of cycle
// [RQ23] No completion pulse in one-channel burst
// [RQ24] Accumulator saturates at maximum, never wraps
module csa_sequencer
  import csa_pkg::*;
#(
  parameter int SLOT_CYC = CLK_HZ / CONV_RATE_SPS,
  parameter int PER0_CYC = CLK_HZ / RATE0_SPS,
  parameter int PER1_CYC = CLK_HZ / RATE1_SPS,
  parameter int PER2_CYC = CLK_HZ / RATE2_SPS,
  parameter int PER3_CYC = CLK_HZ / RATE3_SPS
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire csa_bus_req_type bus_req,
  output logic [31:0] rdata,
  input wire csa_sample_type sample,
  output logic conv_active,
  output logic [2:0] conv_chan,
  output logic sleep,
  output logic alert_n
);

  // First enabled channel at or after a start index
  function automatic logic [2:0] next_ch(input logic [2:0] from, input logic [4:0] act);
    logic [2:0] r;
    r = NO_CH;
    for (int i = 4; i >= 0; i--)
    begin
      if (i >= int'(from) && act[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : next_ch

  // One running-average step, weight one eighth
  function automatic logic signed [17:0] avg_run(input logic signed [17:0] x, input logic signed [17:0] a);
    logic signed [18:0] d;
    logic signed [18:0] s;
    d = 19'(x) - 19'(a);
    s = d >>> 3;
    // Final steps of one, so a steady input is reached exactly
    if (s == 19'sh0 && d != 19'sh0)
    begin
      s = d[18] ? -19'sh1 : 19'sh1;
    end
    return 18'(19'(a) + s);
  endfunction : avg_run

  // Configuration and status registers
  logic [31:0] ctrl_q;
  logic [7:0] accsrc_q;
  logic [15:0] limit_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  // Sequencer state
  csa_state_type st_q;
  csa_state_type st_d;
  logic [2:0] ch_q;
  logic [2:0] ch_d;
  logic [2:0] pass_q;
  logic [2:0] pass_d;
  logic [23:0] slot_q;
  logic [23:0] per_q;
  logic [9:0] cc_q;
  logic signed [16:0] off_q;
  // Per-channel results
  logic signed [55:0] acc_q [4];
  logic [31:0] cnt_q [4];
  logic [31:0] last_q [4];
  logic signed [17:0] avgs_q [4];
  logic signed [17:0] avgb_q [4];
  logic signed [20:0] sums_q [4];
  logic signed [20:0] sumb_q [4];
  // Output registers
  logic alert_n_q;
  logic [31:0] rdata_q;

  // Control field decode
  csa_mode_type mode;
  logic [3:0] chan_en;
  logic [1:0] rate;
  logic any_ch;
  logic single_mode;
  logic b2b_mode;
  logic [4:0] act5;
  assign mode = csa_mode_type'(ctrl_q[2:0]);
  assign chan_en = ctrl_q[CTRL_EN_LSB +: 4];
  assign rate = ctrl_q[CTRL_RATE_LSB +: 2];
  assign any_ch = |chan_en;
  assign single_mode = (mode == MODE_SINGLE) || (mode == MODE_SINGLE8);
  assign b2b_mode = (mode == MODE_BURST) || (mode == MODE_FAST);
  // [RQ8] calibration slot dropped in burst
  assign act5 = {mode != MODE_BURST, chan_en};

  // Register port strobes
  logic wr_ctrl;
  logic snap;
  logic [7:0] stat_clr;
  assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
  assign snap = bus_req.wr && (bus_req.addr == ADDR_CMD) && (|bus_req.wdata[1:0]);
  assign stat_clr = (bus_req.wr && bus_req.addr == ADDR_STATUS) ? bus_req.wdata[7:0] : 8'h00;

  // Channel walk and timing decode
  logic [2:0] first_ch;
  logic [2:0] next_after;
  logic slot_end;
  logic [23:0] per_cyc;
  logic per_done;
  logic last_slot;
  logic cyc_end;
  logic new_cyc;
  logic upd;
  // [RQ4] next enabled channel in order
  // [RQ6] disabled channels skipped
  assign first_ch = next_ch(3'h0, act5);
  assign next_after = next_ch(3'(ch_q + 3'h1), act5);
  // [RQ10] fixed slot per conversion
  // [RQ12] same slot for calibration
  assign slot_end = (slot_q == 24'(SLOT_CYC - 1));
  assign per_cyc = (rate == 2'h0) ? 24'(PER0_CYC) :
                   (rate == 2'h1) ? 24'(PER1_CYC) :
                   (rate == 2'h2) ? 24'(PER2_CYC) : 24'(PER3_CYC);
  assign per_done = (per_q >= 24'(per_cyc - 24'h1));
  assign last_slot = (next_after == NO_CH);
  // [RQ2] cycle ends after last channel
  assign cyc_end = (st_q == ST_CALC) && last_slot;
  assign upd = (st_q == ST_CALC) && !ch_q[2];

  // Next-state decode
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_SLEEP:
      begin
        // [RQ7] no channels means stay asleep
        // [RQ14] single shot waits for snapshot
        if (any_ch && (single_mode ? snap : 1'b1))
        begin
          st_d = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (slot_end)
        begin
          st_d = ST_CALC;
        end
      end
      ST_CALC:
      begin
        if (!last_slot)
        begin
          st_d = ST_CONV;
        end
        else if (!any_ch)
        begin
          st_d = ST_SLEEP;
        end
        // [RQ5] idle out the rest of the period
        else if (mode == MODE_CONT)
        begin
          st_d = ST_GAP;
        end
        // [RQ8] restart at once, no sleep
        // [RQ17] eight passes back to back
        else if (b2b_mode || (mode == MODE_SINGLE8 && pass_q != LAST_PASS))
        begin
          st_d = ST_CONV;
        end
        // [RQ15] single shot back to sleep
        else
        begin
          st_d = ST_SLEEP;
        end
      end
      ST_GAP:
      begin
        if (!any_ch || mode != MODE_CONT)
        begin
          st_d = ST_SLEEP;
        end
        else if (per_done)
        begin
          st_d = ST_CONV;
        end
      end
      default:
      begin
        st_d = ST_SLEEP;
      end
    endcase
  end

  // Cycle start, channel and pass selection
  assign new_cyc = (st_d == ST_CONV) && (st_q != ST_CONV) && !(st_q == ST_CALC && !last_slot);
  assign ch_d = new_cyc ? first_ch : ((st_q == ST_CALC) ? next_after : ch_q);
  assign pass_d = (new_cyc && st_q == ST_SLEEP) ? 3'h0 : ((new_cyc && st_q == ST_CALC) ? 3'(pass_q + 3'h1) : pass_q);

  // Sequencer registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_SLEEP;
      ch_q <= 3'h0;
      pass_q <= 3'h0;
      slot_q <= 24'h000000;
      per_q <= 24'h000000;
    end
    else
    begin
      st_q <= st_d;
      ch_q <= ch_d;
      pass_q <= pass_d;
      slot_q <= (st_q == ST_CONV) ? 24'(slot_q + 24'h1) : 24'h000000;
      per_q <= new_cyc ? 24'h000000 : ((&per_q) ? per_q : 24'(per_q + 24'h1));
    end
  end

  // Sample arithmetic
  logic signed [17:0] corr;
  logic signed [17:0] bus18;
  logic signed [13:0] bus14;
  logic signed [31:0] pwr;
  logic [1:0] src;
  logic signed [55:0] add_val;
  logic signed [55:0] acc_cur;
  logic signed [56:0] sum57;
  logic acc_ovf;
  logic signed [55:0] acc_new;
  logic cnt_full;
  logic lim_hit;
  // [RQ9] offset held from last calibration slot
  assign corr = 18'($signed(sample.sense)) - 18'(off_q);
  assign bus18 = 18'($signed(sample.bus));
  assign bus14 = $signed(sample.bus[16:3]);
  // [RQ3] power from corrected sense and bus
  assign pwr = corr * bus14;
  assign src = accsrc_q[{ch_q[1:0], 1'b0} +: 2];
  // [RQ1] accumulator source select
  assign add_val = (src == SRC_SENSE) ? 56'(corr) : ((src == SRC_BUS) ? 56'(bus18) : 56'(pwr));
  assign acc_cur = acc_q[ch_q[1:0]];
  assign sum57 = 57'(acc_cur) + 57'(add_val);
  assign acc_ovf = (sum57[56] != sum57[55]);
  // [RQ24] clamp instead of wrapping
  assign acc_new = acc_ovf ? (sum57[56] ? ACC_MIN : ACC_MAX) : sum57[55:0];
  assign cnt_full = &cnt_q[ch_q[1:0]];
  assign lim_hit = (corr > 18'($signed(limit_q)));

  // Averaging and eight-sample sums
  logic signed [20:0] sums_new;
  logic signed [20:0] sumb_new;
  assign sums_new = ((pass_q == 3'h0) ? 21'sh0 : sums_q[ch_q[1:0]]) + 21'(corr);
  assign sumb_new = ((pass_q == 3'h0) ? 21'sh0 : sumb_q[ch_q[1:0]]) + 21'(bus18);

  // Per-channel result storage
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      off_q <= 17'sh0;
      for (int i = 0; i < 4; i++)
      begin
        acc_q[i] <= 56'sh0;
        cnt_q[i] <= 32'h00000000;
        last_q[i] <= 32'h00000000;
        avgs_q[i] <= 18'sh0;
        avgb_q[i] <= 18'sh0;
        sums_q[i] <= 21'sh0;
        sumb_q[i] <= 21'sh0;
      end
    end
    else
    begin
      // [RQ11] calibration slot refreshes offset
      if (st_q == ST_CALC && ch_q == CAL_CH)
      begin
        off_q <= $signed(sample.sense);
      end
      // [RQ3] accumulate and update after each channel slot
      // [RQ13] same path in single shot
      // [RQ18] every pass adds and counts one
      if (upd)
      begin
        acc_q[ch_q[1:0]] <= acc_new;
        cnt_q[ch_q[1:0]] <= cnt_full ? cnt_q[ch_q[1:0]] : 32'(cnt_q[ch_q[1:0]] + 32'h1);
        // [RQ19] raw result keeps latest sample
        last_q[ch_q[1:0]] <= {bus18[16:1], corr[17:2]};
        sums_q[ch_q[1:0]] <= sums_new;
        sumb_q[ch_q[1:0]] <= sumb_new;
        if (mode == MODE_SINGLE8)
        begin
          // [RQ17] mean of eight on last pass
          if (pass_q == LAST_PASS)
          begin
            avgs_q[ch_q[1:0]] <= sums_new[20:3];
            avgb_q[ch_q[1:0]] <= sumb_new[20:3];
          end
        end
        else
        begin
          avgs_q[ch_q[1:0]] <= avg_run(corr, avgs_q[ch_q[1:0]]);
          avgb_q[ch_q[1:0]] <= avg_run(bus18, avgb_q[ch_q[1:0]]);
        end
      end
    end
  end

  // Alert event collection
  logic [3:0] evt_ovf;
  logic [3:0] evt_lim;
  logic [7:0] evt;
  logic latched;
  logic cc_fire;
  logic cc_act;
  // [RQ20] overflow and limit events
  assign evt_ovf = (upd && (acc_ovf || cnt_full)) ? (4'h1 << ch_q[1:0]) : 4'h0;
  assign evt_lim = (upd && lim_hit) ? (4'h1 << ch_q[1:0]) : 4'h0;
  assign evt = {evt_lim, evt_ovf};
  // [RQ22] pending events post only at cycle end
  assign pend_d = cyc_end ? 8'h00 : (pend_q | evt);
  assign stat_d = (stat_q & ~stat_clr) | (cyc_end ? (pend_q | evt) : 8'h00);
  assign latched = ((|stat_q[3:0]) && ctrl_q[CTRL_OVFEN_BIT]) || ((|stat_q[7:4]) && ctrl_q[CTRL_LIMEN_BIT]);
  // [RQ23] suppressed for one-channel burst
  assign cc_fire = cyc_end && ctrl_q[CTRL_CCEN_BIT] && !(mode == MODE_BURST && $onehot(chan_en));
  assign cc_act = (cc_q != 10'h000);

  // Status, pulse timer and alert pin
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q <= 8'h00;
      stat_q <= 8'h00;
      cc_q <= 10'h000;
      alert_n_q <= 1'b1;
    end
    else
    begin
      pend_q <= pend_d;
      stat_q <= stat_d;
      // [RQ21] fixed-length completion pulse
      cc_q <= cc_fire ? 10'(CC_PULSE_CYC) : (cc_act ? 10'(cc_q - 10'h1) : 10'h000);
      // [RQ21] latched alerts hold pin low
      alert_n_q <= !(cc_act || latched);
    end
  end

  // Software-written registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= CTRL_RESET;
      accsrc_q <= ACCSRC_RESET;
      limit_q <= LIMIT_RESET;
    end
    else if (bus_req.wr)
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= bus_req.wdata & CTRL_MASK;
      end
      if (bus_req.addr == ADDR_ACCSRC)
      begin
        accsrc_q <= bus_req.wdata[7:0];
      end
      if (bus_req.addr == ADDR_LIMIT)
      begin
        limit_q <= bus_req.wdata[15:0];
      end
    end
  end

  // Read decode
  logic [1:0] rch;
  logic [31:0] chw;
  logic [31:0] avw;
  logic [31:0] rd_val;
  assign rch = bus_req.addr[5:4];
  assign chw = (bus_req.addr[3:2] == 2'h0) ? acc_q[rch][31:0] :
               (bus_req.addr[3:2] == 2'h1) ? {8'h00, acc_q[rch][55:32]} :
               (bus_req.addr[3:2] == 2'h2) ? cnt_q[rch] : last_q[rch];
  assign avw = {avgb_q[bus_req.addr[3:2]][16:1], avgs_q[bus_req.addr[3:2]][17:2]};
  assign rd_val = (bus_req.addr == ADDR_CTRL) ? ctrl_q :
                  (bus_req.addr == ADDR_ACCSRC) ? {24'h000000, accsrc_q} :
                  (bus_req.addr == ADDR_STATUS) ? {21'h000000, !alert_n_q, st_q == ST_SLEEP, st_q != ST_SLEEP, stat_q} :
                  (bus_req.addr == ADDR_LIMIT) ? {16'h0000, limit_q} :
                  (bus_req.addr == ADDR_OFFSET) ? 32'(off_q) :
                  (bus_req.addr[7:6] == CHBLK_TAG) ? chw :
                  (bus_req.addr[7:4] == AVGBLK_TAG) ? avw : 32'h00000000;

  // Read data register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rd_val : 32'h00000000;
    end
  end

  // Output drive
  assign rdata = rdata_q;
  assign conv_active = (st_q == ST_CONV);
  assign conv_chan = ch_q;
  assign sleep = (st_q == ST_SLEEP);
  assign alert_n = alert_n_q;

  // Checks
  property p_conv_enabled;
    @(posedge mclk) disable iff (!nrst) (st_d == ST_CONV && st_q != ST_CONV) |-> act5[ch_d];
  endproperty
  a_conv_enabled: assert property (p_conv_enabled) else $error("disabled channel converted"); // [RQ6]

  property p_burst_nocal;
    @(posedge mclk) disable iff (!nrst) (mode == MODE_BURST && st_d == ST_CONV && st_q != ST_CONV) |-> (ch_d != CAL_CH);
  endproperty
  a_burst_nocal: assert property (p_burst_nocal) else $error("calibration slot in burst"); // [RQ8]

  property p_burst_off;
    @(posedge mclk) disable iff (!nrst) (mode == MODE_BURST && st_q == ST_CALC && ch_q != CAL_CH) |=> $stable(off_q);
  endproperty
  a_burst_off: assert property (p_burst_off) else $error("offset changed in burst"); // [RQ9]

  property p_slot_len;
    @(posedge mclk) disable iff (!nrst) (st_q == ST_CONV && st_d == ST_CALC) |-> slot_end;
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong"); // [RQ10]

  property p_single_wait;
    @(posedge mclk) disable iff (!nrst) (st_q == ST_SLEEP && single_mode && !snap) |=> (st_q == ST_SLEEP);
  endproperty
  a_single_wait: assert property (p_single_wait) else $error("single shot left sleep without snapshot"); // [RQ14]

  property p_all_off;
    @(posedge mclk) disable iff (!nrst) (st_q == ST_SLEEP && !any_ch) |=> (st_q == ST_SLEEP);
  endproperty
  a_all_off: assert property (p_all_off) else $error("converting with no channel"); // [RQ7]

  property p_gap_cont;
    @(posedge mclk) disable iff (!nrst) (st_q == ST_GAP && mode != MODE_CONT) |=> (st_q == ST_SLEEP);
  endproperty
  a_gap_cont: assert property (p_gap_cont) else $error("sleep gap outside continuous mode"); // [RQ5]

  property p_sat;
    @(posedge mclk) disable iff (!nrst) (upd && acc_cur == ACC_MAX && !add_val[55]) |-> (acc_new == ACC_MAX);
  endproperty
  a_sat: assert property (p_sat) else $error("accumulator wrapped"); // [RQ24]

  property p_cc_pulse;
    @(posedge mclk) disable iff (!nrst) (cc_fire && !cc_act) |=> cc_act ##[499:499] (cc_act && cc_q == 10'h001);
  endproperty
  a_cc_pulse: assert property (p_cc_pulse) else $error("completion pulse length wrong"); // [RQ21]

  property p_alert_end;
    @(posedge mclk) disable iff (!nrst) $fell(alert_n_q) |-> ($past(cyc_end, 2) || $past(wr_ctrl, 2));
  endproperty
  a_alert_end: assert property (p_alert_end) else $error("alert asserted mid cycle"); // [RQ22]

endmodule : csa_sequencer
